/* logic/stm_map.svh */
// register layout, reset values and address codes of the threshold monitor
`ifndef STM_MAP_SVH
`define STM_MAP_SVH
`define STM_THR_RST_THERM 8'h32
`define STM_THR_RST_INT   8'hb2
`define STM_CTL_BIT       7
`define STM_SIGN_BIT      6
`define STM_STANDBY_CODE  7'h40
`define STM_CLAMP_CODE    7'h65
`define STM_MIN_MAG       6'h25
`define STM_ST_OVER       7
`define STM_ST_UNDER      6
`define STM_ST_OUT        5
`define STM_ST_DEF        1
`define STM_ST_ERR        0
`define STM_PRE_A         4'h9
`define STM_PRE_B         4'h3
`define STM_PRE_FLOAT     4'h5
`define STM_STRAP_VCC     2'h1
`define STM_STRAP_GND     2'h2
`define STM_BIT_LAST      3'h7
`endif

/* logic/stm_pkg.sv */
// types shared by the threshold monitor
package stm_pkg;
  typedef enum logic [2:0] {
    LK_IDLE, LK_ADDR, LK_ACKA, LK_WDATA, LK_ACKW, LK_RDATA, LK_SKIP
  } stm_link_e;
  typedef struct packed {
    logic over;
    logic under;
    logic por;
    logic undervoltage_lockout;
  } stm_sense_s;
  typedef struct packed {
    logic over;
    logic under;
    logic outbit;
    logic dflt;
    logic err;
  } stm_flags_s;
endpackage

/* logic/stm_top.sv */
// smbus threshold monitor: link slave, threshold register, status and outputs
// Functional notes
// - send byte: address, write, ack, eight bits msb first, ack; threshold loads at the data ack, before stop.
// - threshold bits 6..0 are two's complement, 2 degree steps, bit 6 sign.
// - bit 7 is polarity in thermostat variant, under-event mask in interrupt variant.
// - negative full scale code enters standby and suspends comparisons.
// - leaving standby samples the address strap again and latches it.
// - power-on threshold value is +100 degrees, code 0110010.
// - thermostat output polarity follows control bit, active low by default.
// - thermostat asserts at or above threshold, clears at or below threshold minus 4.
// - interrupt output latches; cleared only by status read or threshold write.
// - interrupt on over, or under threshold minus 8 unless masked.
// - under-temperature interrupts stay masked after power-on until host clears mask.
// - status bit 7 sets on upper crossing, bit 6 on lower crossing.
// - any addressed send or receive byte clears status bits 7 and 6.
// - thermostat bit 6 unmasked after power-on; interrupt variant bit 6 reads zero while the bit 7 mask is set.
// - thermostat status bit 5 shows live output state; interrupt variant zero.
// - status bit 1 shows default threshold, cleared only by a send byte.
// - status bit 0 sets on undervoltage, clears on send byte with supply valid.
// - status bits 4..2 read as zero.
// - one address for both directions; receive byte returns status, host nacks.
// - slave address decoded from three-state strap and variant, sampled at power-on.
// - power-on releases both outputs, active-low polarity, status cleared except bit 1, which flags the default threshold.
// - no command byte, single byte transfers only, no alert response protocol.
`include "stm_map.svh"
`timescale 1ns/1ps
`default_nettype none
module stm_top #(
  parameter bit IRQ_VARIANT = 1'b0,
  parameter bit SUFFIX_B    = 1'b0
) (
  input  wire logic            i_clk,
  input  wire logic            i_srst,
  input  wire logic            i_link_clk,
  input  wire logic            i_scl,
  input  wire logic            i_sda,
  output logic                 o_sda_o,
  output logic                 o_sda_oe,
  input  wire logic [1:0]      i_strap,
  input  wire stm_pkg::stm_sense_s i_sense,
  output logic [6:0]           o_dac_code,
  output logic                 o_standby,
  output logic                 o_therm_o,
  output logic                 o_therm_oe,
  output logic                 o_alert_o,
  output logic                 o_alert_oe
);

  // floating strap uses a fixed prefix; its low bit then depends on the suffix
  function automatic logic [6:0] addr_of(input logic [1:0] strap);
    if (strap == `STM_STRAP_VCC)
      addr_of = {(SUFFIX_B ? `STM_PRE_B : `STM_PRE_A), 1'b0, IRQ_VARIANT, 1'b0};
    else if (strap == `STM_STRAP_GND)
      addr_of = {(SUFFIX_B ? `STM_PRE_B : `STM_PRE_A), 1'b0, IRQ_VARIANT, 1'b1};
    else
      addr_of = {`STM_PRE_FLOAT, 1'b0, IRQ_VARIANT, ~SUFFIX_B};
  endfunction

  // ---------------- core domain ----------------
  stm_pkg::stm_sense_s sense_m, sense_q;
  logic [1:0] strap_m, strap_q;
  logic [2:0] wr_sync, rd_sync;
  always_ff @(posedge i_clk) begin
    sense_m <= i_sense;
    sense_q <= sense_m;
    // strap is static but still passes two flops like any pin
    strap_m <= i_strap;
    strap_q <= strap_m;
  end

  logic       wr_tgl_q, rd_tgl_q, rd_ack_q, addr_tgl_q;
  logic [7:0] wbyte_q;
  always_ff @(posedge i_clk) begin
    wr_sync <= {wr_sync[1:0], wr_tgl_q};
    rd_sync <= {rd_sync[1:0], rd_tgl_q};
  end
  // write and read events cross as toggles; the byte behind them is held still
  wire wr_evt  = wr_sync[1] ^ wr_sync[2];
  wire rd_evt  = rd_sync[1] ^ rd_sync[2];
  wire rst_c   = i_srst | sense_q.por;

  logic [7:0] thr_q;
  logic       act_q, alert_q, strap_pend_q;
  logic [6:0] addr_c_q;
  stm_pkg::stm_flags_s fl_q;
  logic [7:0] shadow_q;

  wire [6:0] thr_v   = thr_q[`STM_SIGN_BIT:0];
  wire       ctl     = thr_q[`STM_CTL_BIT];
  wire       standby = (thr_v == `STM_STANDBY_CODE);
  wire       low_cd  = thr_v[`STM_SIGN_BIT] && !standby
                       && (thr_v[5:0] < `STM_MIN_MAG);
  wire [6:0] dac_d   = low_cd ? `STM_CLAMP_CODE : thr_v;
  wire       new_sb  = (wbyte_q[`STM_SIGN_BIT:0] == `STM_STANDBY_CODE);
  wire       cmp_ok  = !standby;
  wire       over_e  = cmp_ok && sense_q.over;
  wire       under_e = cmp_ok && sense_q.under
                       && !(IRQ_VARIANT && ctl);
  // standby freezes the thermostat state rather than clearing it
  wire       act_d   = !cmp_ok ? act_q :
                       sense_q.over ? 1'b1 :
                       sense_q.under ? 1'b0 : act_q;
  // any addressed transfer clears, write or read alike
  wire       clr_ev  = wr_evt | rd_evt;
  wire       alert_d = (IRQ_VARIANT && (over_e || under_e))
                       || (alert_q && !clr_ev);
  // hysteresis edge on the pin comes from the analog lower threshold, 4 below; the interrupt variant never pulls the pin
  wire       pin_low = IRQ_VARIANT ? 1'b0 : (act_q ^ ctl);
  // reserved bits are tied low; nothing in the block can set them
  wire [7:0] status  = {fl_q.over, fl_q.under, fl_q.outbit,
                        3'h0, fl_q.dflt, fl_q.err};

  // threshold register; a write lands one core cycle after its event is seen
  always_ff @(posedge i_clk) begin
    if (rst_c) begin
      thr_q <= IRQ_VARIANT ? `STM_THR_RST_INT : `STM_THR_RST_THERM;
    end else if (wr_evt) begin
      thr_q <= wbyte_q;
    end
  end

  // comparator state and alert latch
  always_ff @(posedge i_clk) begin
    if (rst_c) begin
      act_q   <= 1'b0;
      alert_q <= 1'b0;
    end else begin
      act_q   <= act_d;
      alert_q <= alert_d;
    end
  end

  // status flags; set beats clear so a crossing in the clearing cycle is kept
  always_ff @(posedge i_clk) begin
    if (rst_c) begin
      fl_q <= '0;
    end else begin
      fl_q.outbit <= IRQ_VARIANT ? 1'b0 : act_d;
      fl_q.over   <= over_e || (fl_q.over && !clr_ev);
      fl_q.under  <= under_e || (fl_q.under && !clr_ev);
      fl_q.err    <= sense_q.undervoltage_lockout || (fl_q.err && !wr_evt);
      fl_q.dflt   <= (fl_q.dflt && !wr_evt) || strap_pend_q;
    end
  end

  // snapshot for the link, taken when a read is addressed
  always_ff @(posedge i_clk) begin
    if (rst_c) begin
      shadow_q <= 8'h00;
      rd_ack_q <= 1'b0;
    end else if (rd_evt) begin
      shadow_q <= status;
      rd_ack_q <= ~rd_ack_q;
    end
  end

  // strap taken after power-on release and on exit from standby
  wire strap_take = strap_pend_q || (wr_evt && standby && !new_sb);
  always_ff @(posedge i_clk) begin
    if (rst_c) begin
      strap_pend_q <= 1'b1;
      addr_c_q     <= 7'h00;
      addr_tgl_q   <= 1'b0;
    end else if (strap_take) begin
      addr_c_q     <= addr_of(strap_q);
      addr_tgl_q   <= ~addr_tgl_q;
      strap_pend_q <= 1'b0;
    end
  end

  // dac code and standby flag follow the threshold register one cycle later
  always_ff @(posedge i_clk) begin
    if (rst_c) begin
      o_dac_code <= `STM_CLAMP_CODE;
      o_standby  <= 1'b0;
    end else begin
      o_dac_code <= dac_d;
      o_standby  <= standby;
    end
  end

  // open drain pins: the level is always low, only the enable moves
  always_ff @(posedge i_clk) begin
    if (rst_c) begin
      o_therm_o  <= 1'b0;
      o_therm_oe <= 1'b0;
    end else begin
      o_therm_o  <= 1'b0;
      o_therm_oe <= pin_low;
    end
  end

  always_ff @(posedge i_clk) begin
    if (rst_c) begin
      o_alert_o  <= 1'b0;
      o_alert_oe <= 1'b0;
    end else begin
      o_alert_o  <= 1'b0;
      o_alert_oe <= IRQ_VARIANT ? alert_q : 1'b0;
    end
  end

  // ---------------- link domain ----------------
  logic       lrst_m, lrst_q;
  logic [1:0] scl_s, sda_s;
  logic       scl_p, sda_p;
  logic [2:0] at_sync, ak_sync;
  // reset reaches the link side through two flops of its own
  always_ff @(posedge i_link_clk) begin
    lrst_m <= i_srst;
    lrst_q <= lrst_m;
  end

  // pins are asynchronous; the second flop and a delayed copy of it feed the decoder
  always_ff @(posedge i_link_clk) begin
    scl_s <= {scl_s[0], i_scl};
    sda_s <= {sda_s[0], i_sda};
    scl_p <= scl_s[1];
    sda_p <= sda_s[1];
  end

  always_ff @(posedge i_link_clk) begin
    at_sync <= {at_sync[1:0], addr_tgl_q};
    ak_sync <= {ak_sync[1:0], rd_ack_q};
  end
  wire scl   = scl_s[1];
  wire sda   = sda_s[1];
  wire rise  = scl && !scl_p;
  wire fall  = !scl && scl_p;
  wire start = scl && scl_p && sda_p && !sda;
  wire stop  = scl && scl_p && !sda_p && sda;
  wire a_new = at_sync[1] ^ at_sync[2];

  stm_pkg::stm_link_e st_q;
  logic [7:0] sh_q, tx_q;
  logic [3:0] cnt_q;
  logic       rw_q;
  logic [6:0] addr_l_q;
  // address match only after all eight bits; a miss ignores the rest up to stop
  wire        hit = (sh_q[7:1] == addr_l_q);

  // core value is held still for many link cycles after its toggle
  always_ff @(posedge i_link_clk) begin
    if (lrst_q) begin
      addr_l_q <= 7'h00;
    end else if (a_new) begin
      addr_l_q <= addr_c_q;
    end
  end

  always_ff @(posedge i_link_clk) begin
    o_sda_o <= 1'b0;
  end

  always_ff @(posedge i_link_clk) begin
    if (lrst_q) begin
      st_q     <= stm_pkg::LK_IDLE;
      sh_q     <= 8'h00;
      tx_q     <= 8'h00;
      cnt_q    <= 4'h0;
      rw_q     <= 1'b0;
      wbyte_q  <= 8'h00;
      wr_tgl_q <= 1'b0;
      rd_tgl_q <= 1'b0;
      o_sda_oe <= 1'b0;
    end else begin
      if (start) begin
        st_q     <= stm_pkg::LK_ADDR;
        cnt_q    <= 4'h0;
        o_sda_oe <= 1'b0;
      end else if (stop) begin
        st_q     <= stm_pkg::LK_IDLE;
        o_sda_oe <= 1'b0;
      end else if (rise) begin
        if (st_q == stm_pkg::LK_ADDR || st_q == stm_pkg::LK_WDATA) begin
          sh_q  <= {sh_q[6:0], sda};
          cnt_q <= cnt_q + 4'h1;
        end
      end else if (fall) begin
        unique case (st_q)
          stm_pkg::LK_ADDR: begin
            if (cnt_q[3]) begin
              if (hit) begin
                o_sda_oe <= 1'b1;
                rw_q     <= sh_q[0];
                st_q     <= stm_pkg::LK_ACKA;
                if (sh_q[0]) begin
                  rd_tgl_q <= ~rd_tgl_q;
                end
              end else begin
                st_q <= stm_pkg::LK_SKIP;
              end
            end
          end
          stm_pkg::LK_ACKA: begin
            cnt_q <= 4'h0;
            // limitation: the snapshot must have landed, so the host keeps the clock high
            if (rw_q) begin
              tx_q     <= {shadow_q[6:0], 1'b0};
              o_sda_oe <= ~shadow_q[7];
              st_q     <= stm_pkg::LK_RDATA;
            end else begin
              o_sda_oe <= 1'b0;
              st_q     <= stm_pkg::LK_WDATA;
            end
          end
          stm_pkg::LK_WDATA: begin
            if (cnt_q[3]) begin
              o_sda_oe <= 1'b1;
              wbyte_q  <= sh_q;
              wr_tgl_q <= ~wr_tgl_q;
              st_q     <= stm_pkg::LK_ACKW;
            end
          end
          stm_pkg::LK_ACKW: begin
            o_sda_oe <= 1'b0;
            st_q     <= stm_pkg::LK_SKIP;
          end
          stm_pkg::LK_RDATA: begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q[2:0] == `STM_BIT_LAST) begin
              o_sda_oe <= 1'b0;
              st_q     <= stm_pkg::LK_SKIP;
            end else begin
              o_sda_oe <= ~tx_q[7];
              tx_q     <= {tx_q[6:0], 1'b0};
            end
          end
          stm_pkg::LK_IDLE, stm_pkg::LK_SKIP: begin
            o_sda_oe <= 1'b0;
          end
          // the eighth code of the state word is unused; fall back to idle
          default: begin
            st_q <= stm_pkg::LK_IDLE;
          end
        endcase
      end
    end
  end

  // snapshot echo is kept for a later wait state; the link does not use it yet
  wire unused_ok = ak_sync[2] ^ ak_sync[1];
endmodule
`default_nettype wire

/* verif/stm_host.sv */
// smbus host model for the monitor's serial lines
`timescale 1ns/1ps
`default_nettype none
module stm_host (
  input  wire logic       i_sda,
  output logic            o_scl,
  output logic            o_pull_low,
  output logic            o_done,
  output logic [7:0]      o_byte
);
  localparam int HP = 1000;
  initial begin
    o_scl = 1'b1;
    o_pull_low = 1'b0;
    o_done = 1'b0;
    o_byte = 8'h00;
  end
  // data moves only while the clock is low; sampled at the end of the high phase
  task automatic bit_io(input logic b, output logic s);
    o_pull_low = !b;
    #HP o_scl = 1'b1;
    #HP s = i_sda;
    o_scl = 1'b0;
  endtask
  // address byte, one data byte msb first, then stop; a read ends with a nack
  task automatic xfer(input logic [6:0] a, input logic rd, input logic [7:0] wd,
                      output logic ack, output logic [7:0] q);
    logic [7:0] ab;
    logic       s;
    ab = {a, rd};
    o_pull_low = 1'b1;
    #HP o_scl = 1'b0;
    for (int i = 7; i >= 0; i--) bit_io(ab[i], s);
    bit_io(1'b1, s);
    ack = !s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(rd | wd[i], s);
      q[i] = s;
    end
    bit_io(1'b1, s);
    if (!rd) ack = ack & !s;
    o_pull_low = 1'b1;
    #HP o_scl = 1'b1;
    #HP o_pull_low = 1'b0;
    #HP;
    if (rd && ack) begin
      o_byte = q;
      o_done = 1'b1;
      #1 o_done = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* verif/stm_top_sva.sv */
// port checker for the threshold monitor
`timescale 1ns/1ps
`default_nettype none
module stm_top_sva #(
  parameter bit IRQ_VARIANT = 1'b0,
  parameter bit SUFFIX_B    = 1'b0
) (
  input wire logic                i_clk,
  input wire logic                i_srst,
  input wire logic                i_link_clk,
  input wire logic                i_scl,
  input wire logic                i_sda,
  input wire logic                o_sda_o,
  input wire logic                o_sda_oe,
  input wire logic [1:0]          i_strap,
  input wire stm_pkg::stm_sense_s i_sense,
  input wire logic [6:0]          o_dac_code,
  input wire logic                o_standby,
  input wire logic                o_therm_o,
  input wire logic                o_therm_oe,
  input wire logic                o_alert_o,
  input wire logic                o_alert_oe
);
  sequence s_stop;
    i_scl && $rose(i_sda);
  endsequence
  // three samples so an update launched on the entry edge is not mistaken for a change
  sequence s_asleep;
    o_standby[*3];
  endsequence
  // clock line high keeps a threshold write from landing inside the window
  sequence s_quiet;
    (i_scl && !i_sense.over && !i_sense.under)[*8];
  endsequence
  chk_ack_on_low: assert property (@(posedge i_link_clk) disable iff (i_srst)
    $rose(o_sda_oe) |-> !i_scl) else $error("data line pulled while clock high");
  chk_ack_stands: assert property (@(posedge i_link_clk) disable iff (i_srst)
    $rose(o_sda_oe) |-> o_sda_oe[*8]) else $error("data bit released early");
  chk_stop_frees: assert property (@(posedge i_link_clk) disable iff (i_srst)
    s_stop |-> ##[0:4] !o_sda_oe) else $error("data line held after stop");
  chk_reset_outs: assert property (@(posedge i_clk)
    i_srst |=> !o_therm_oe && !o_alert_oe) else $error("output driven in reset");
  chk_dac_default: assert property (@(posedge i_clk) disable iff (i_srst)
    $fell(i_srst) |-> ##[1:3] o_dac_code == 7'h32) else $error("no default code");
  chk_dac_clamp: assert property (@(posedge i_clk) disable iff (i_srst)
    !(o_dac_code > 7'h40 && o_dac_code < 7'h65)) else $error("code below clamp");
  chk_standby_hold: assert property (@(posedge i_clk) disable iff (i_srst)
    s_asleep |-> $stable(o_therm_oe)) else $error("output moved in standby");
  chk_hyst_hold: assert property (@(posedge i_clk) disable iff (i_srst)
    s_quiet |-> $stable(o_therm_oe)) else $error("output moved inside band");
  chk_alert_quiet: assert property (@(posedge i_clk) disable iff (i_srst)
    !IRQ_VARIANT |-> !o_alert_oe) else $error("alert driven in thermostat variant");
  chk_sda_drain: assert property (@(posedge i_link_clk) disable iff (i_srst)
    o_sda_oe |-> !o_sda_o) else $error("data line driven high");
endmodule
bind stm_top stm_top_sva #(.IRQ_VARIANT(IRQ_VARIANT), .SUFFIX_B(SUFFIX_B)) i_stm_top_sva (
  .i_clk(i_clk), .i_srst(i_srst), .i_link_clk(i_link_clk), .i_scl(i_scl), .i_sda(i_sda),
  .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .i_strap(i_strap), .i_sense(i_sense),
  .o_dac_code(o_dac_code), .o_standby(o_standby), .o_therm_o(o_therm_o),
  .o_therm_oe(o_therm_oe), .o_alert_o(o_alert_o), .o_alert_oe(o_alert_oe));
`default_nettype wire

/* verif/stm_top_test.sv */
// self-checking bench for the threshold monitor
`timescale 1ns/1ps
`default_nettype none
module stm_top_test;
  localparam logic [6:0] A_VCC = 7'h48;
  logic                clk, lclk, srst, scl, pull, sda, sda_o, sda_oe;
  logic                stby, th_o, th_oe, al_o, al_oe, done;
  logic [1:0]          strap;
  logic [6:0]          dac;
  logic [7:0]          rbyte, v;
  stm_pkg::stm_sense_s sense;
  logic [7:0]          expq[$];
  int                  err_count, n_tests, cyc;
  assign sda = !(pull || sda_oe);
  stm_top #(.IRQ_VARIANT(1'b0), .SUFFIX_B(1'b0)) i_stm_top (
    .i_clk(clk), .i_srst(srst), .i_link_clk(lclk), .i_scl(scl), .i_sda(sda),
    .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_strap(strap), .i_sense(sense),
    .o_dac_code(dac), .o_standby(stby), .o_therm_o(th_o), .o_therm_oe(th_oe),
    .o_alert_o(al_o), .o_alert_oe(al_oe));
  stm_host i_stm_host (.i_sda(sda), .o_scl(scl), .o_pull_low(pull), .o_done(done),
    .o_byte(rbyte));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #7;
    forever #40 lclk = ~lclk;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wrap_up;
    if (expq.size() != 0) begin
      err_count++;
      $display("unexpected status queue: expected 0 seen %0d", expq.size());
    end
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // sense inputs go through two flops, so give them time before looking
  task automatic st(input logic [3:0] s);
    step(1);
    sense = s;
    step(8);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic       k;
    logic [7:0] q;
    i_stm_host.xfer(a, 1'b0, d, k, q);
    chk("write ack", 8'h01, {7'h0, k});
    step(8);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e, input logic ak);
    logic       k;
    logic [7:0] q;
    if (ak) expq.push_back(e);
    i_stm_host.xfer(a, 1'b1, 8'hff, k, q);
    chk("read ack", {7'h0, ak}, {7'h0, k});
  endtask
  initial begin
    forever begin
      @(posedge done);
      if (expq.size() > 0) chk("status", expq.pop_front(), rbyte);
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      wrap_up();
    end
  end
  initial begin
    srst = 1'b1;
    strap = 2'h1;
    sense = 4'h4;
    err_count = 0;
    n_tests = 0;
    cyc = 0;
    v = 8'($urandom(32'h73f7));
    // six cycles so the slower link side also sees three edges of reset
    step(6);
    srst = 1'b0;
    step(3);
    chk("dac code", 8'h32, {1'b0, dac});
    chk("therm oe", 8'h00, {7'h0, th_oe});
    chk("alert oe", 8'h00, {7'h0, al_oe});
    chk("pin levels", 8'h00, {5'h0, th_o, al_o, sda_o});
    step(30);
    st(4'h0);
    rd(A_VCC, 8'h42, 1'b1);
    rd(A_VCC, 8'h02, 1'b1);
    st(4'h8);
    chk("therm oe", 8'h01, {7'h0, th_oe});
    st(4'h0);
    chk("therm oe", 8'h01, {7'h0, th_oe});
    rd(A_VCC, 8'ha2, 1'b1);
    rd(A_VCC, 8'h22, 1'b1);
    st(4'h4);
    chk("therm oe", 8'h00, {7'h0, th_oe});
    st(4'h1);
    st(4'h0);
    rd(A_VCC, 8'h43, 1'b1);
    rd(A_VCC, 8'h03, 1'b1);
    v = {2'b10, 6'($urandom)};
    wr(A_VCC, v);
    chk("dac code", {1'b0, v[6:0]}, {1'b0, dac});
    chk("therm oe", 8'h01, {7'h0, th_oe});
    rd(A_VCC, 8'h00, 1'b1);
    for (int k = 0; k < 3; k++) begin
      v = {2'b01, 6'(1 + $urandom % 36)};
      wr(A_VCC, v);
      chk("dac code", 8'h65, {1'b0, dac});
    end
    wr(A_VCC, 8'h40);
    chk("standby", 8'h01, {7'h0, stby});
    strap = 2'h2;
    wr(A_VCC, 8'h32);
    chk("standby", 8'h00, {7'h0, stby});
    step(40);
    rd(A_VCC, 8'h00, 1'b0);
    rd(7'h49, 8'h00, 1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire
